// *** hw/efc_output_stage.sv ***
/*
  Energy-to-frequency output stage for three converter outputs: mode
  dependent power selection, two-stage conversion, pin gating, event
  flags with one interrupt line, sum sign tracking and synchronised
  latching of the phase energy accumulators.
  Assumes phase powers arrive at 8 kHz as one-cycle strobes on the core
  clock, and configuration is held by the host register block.
*/
`timescale 1ns/1ns
module efc_output_stage #(
  parameter int LOW_TICKS = efc_pkg::LOW_TICKS
) (
  input  wire logic                core_clk,            // 125 MHz clock.
  input  wire logic                rst_b,               // Async reset, low.
  input  wire efc_pkg::efc_cfg_t   cfg,                 // Configuration.
  input  wire logic                pwr_vld,             // New power sample.
  input  wire efc_pkg::efc_powers_t pwr,                // Per-phase powers.
  input  wire logic                flag_wr,             // Flag write strobe.
  input  wire logic [31:0]         flag_wr_data,        // Ones clear flags.
  output logic                     freq_out_one,        // Pin one, low pulse.
  output logic                     freq_out_two,        // Pin two, low pulse.
  output logic                     freq_out_three,      // Pin three, low pulse.
  output logic                     interrupt_line_zero, // Interrupt, low.
  output logic [31:0]              event_flag_reg0,     // Sticky flags.
  output logic [15:0]              power_sign_reg,      // Sum sign bits.
  output efc_pkg::efc_energy_t     energy_regs          // Readable energy.
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [6:0]            div_r;
  logic                  tick_r;
  efc_pkg::efc_powers_t  pwr_r;
  logic signed [39:0]    term_c [3];
  logic signed [39:0]    thr_c [3];
  logic [2:0]            stage_pulse;
  logic [2:0]            stage_neg;
  logic [2:0]            conv_out;
  logic [2:0]            conv_fall;
  logic [2:0]            pin_r;
  logic [2:0]            last_neg_r;
  logic [2:0]            rev_pend_r;
  logic [7:0]            cyc_r [3];
  logic [2:0]            latch_now;
  logic [4:0]            latch_type;
  logic [4:0]            hold_type;
  logic [31:0]           flag_set;
  logic [31:0]           flag_nxt;
  logic [31:0]           flag_r;
  logic [15:0]           sign_nxt;
  logic [15:0]           sign_r;
  logic                  irq_b_r;
  efc_pkg::efc_energy_t  eacc_r;
  efc_pkg::efc_energy_t  ereg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Raw power of one type for one phase; this is what the energy
  // registers accumulate, always signed.
  function automatic logic signed [23:0] raw_power(
    input logic [2:0]              sel,
    input efc_pkg::efc_phase_pwr_t p
  );
    logic signed [23:0] v;
    v = '0;
    case (sel)
      efc_pkg::PT_WATT:  v = p.watt;
      efc_pkg::PT_VAR:   v = p.var_p;
      efc_pkg::PT_VA:    v = p.va;
      efc_pkg::PT_FWATT: v = p.fwatt;
      efc_pkg::PT_FVAR:  v = p.fvar;
      default:           v = '0; // Reserved types feed nothing.
    endcase
    return v;
  endfunction

  // Power fed to a converter after the accumulation mode is applied.
  // The result is one bit wider so that negating full scale cannot wrap.
  function automatic logic signed [24:0] cf_power(
    input logic [2:0]              sel,
    input logic [1:0]              wmode,
    input logic [1:0]              vmode,
    input efc_pkg::efc_phase_pwr_t p
  );
    logic signed [24:0] v;
    logic signed [23:0] ref_w;
    v     = 25'(raw_power(sel, p));
    ref_w = (sel == efc_pkg::PT_FVAR) ? p.fwatt : p.watt;
    if (sel == efc_pkg::PT_WATT || sel == efc_pkg::PT_FWATT) begin
      if (wmode == efc_pkg::ACC_ABS && v < 0) begin
        v = -v;
      end
      // Modes 01 and 10 fall through as signed.
    end else if (sel == efc_pkg::PT_VAR || sel == efc_pkg::PT_FVAR) begin
      if (vmode == efc_pkg::ACC_ABS && v < 0) begin
        v = -v;
      end else if (vmode == efc_pkg::ACC_SADJ && ref_w < 0) begin
        v = -v;
      end
      // Mode 01 falls through as signed.
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // 1 MHz tick from the core clock, and the held power sample.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == 7'(efc_pkg::TICK_DIV - 1));
      if (div_r == 7'(efc_pkg::TICK_DIV - 1)) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 7'h01;
      end
    end
  end

  // The sample is held between 8 kHz updates so every tick adds it again.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_r <= '0;
    end else if (pwr_vld) begin
      pwr_r <= pwr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-output converter chain.
  for (genvar o = 0; o < 3; o++) begin : g_out
    logic [2:0]         sel;
    logic signed [26:0] sum_c;

    assign sel = cfg.output_mode_reg[efc_pkg::SEL_W*o +: efc_pkg::SEL_W];

    // Sum the included phases, then widen and shift by seven bits.
    always_comb begin
      sum_c = '0;
      for (int p = 0; p < 3; p++) begin
        if (cfg.computation_mode_reg[3*o + p]) begin
          sum_c = sum_c + 27'(cf_power(sel,
                    cfg.accumulation_mode_reg[efc_pkg::WMODE_LSB +: 2],
                    cfg.accumulation_mode_reg[efc_pkg::VMODE_LSB +: 2],
                    pwr_r[p]));
        end
      end
      term_c[o] = $signed({{13{sum_c[26]}}, sum_c}) <<< efc_pkg::SHIFT_BITS;
    end

    // The threshold follows the power family of the selected type.
    always_comb begin
      unique case (sel)
        efc_pkg::PT_WATT, efc_pkg::PT_FWATT:
          thr_c[o] = $signed({9'h000, cfg.active_energy_threshold, 7'h00});
        efc_pkg::PT_VAR, efc_pkg::PT_FVAR:
          thr_c[o] = $signed({9'h000, cfg.reactive_energy_threshold, 7'h00});
        efc_pkg::PT_VA:
          thr_c[o] = $signed({9'h000, cfg.apparent_energy_threshold, 7'h00});
        default:
          thr_c[o] = 40'sh0; // Reserved codes stop the converter.
      endcase
    end

    efc_first_stage u_stage (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .tick     (tick_r),
      .term     (term_c[o]),
      .thr      (thr_c[o]),
      .pulse_r  (stage_pulse[o]),
      .neg_r    (stage_neg[o])
    );

    efc_freq_div #(
      .LOW_TICKS (LOW_TICKS)
    ) u_div (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .tick     (tick_r),
      .stage    (stage_pulse[o]),
      .den      (cfg.pulse_divider[o]),
      .out_r    (conv_out[o]),
      .fall_r   (conv_fall[o])
    );

    // Pin gating; the converter keeps running behind a disabled pin.
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        pin_r[o] <= 1'b1;
      end else begin
        pin_r[o] <= cfg.output_mode_reg[efc_pkg::DIS_LSB + o] | conv_out[o];
      end
    end

    // A sign change waits for this output's next fall before it shows.
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        last_neg_r[o] <= 1'b0;
        rev_pend_r[o] <= 1'b0;
      end else begin
        if (stage_pulse[o]) begin
          last_neg_r[o] <= stage_neg[o];
        end
        if (stage_pulse[o] && stage_neg[o] != last_neg_r[o]) begin
          rev_pend_r[o] <= 1'b1;
        end else if (conv_fall[o]) begin
          rev_pend_r[o] <= 1'b0;
        end
      end
    end

    // Count falls between latches; a count of zero behaves as one.
    assign latch_now[o] = conv_fall[o] & cfg.output_mode_reg[efc_pkg::LATCH_LSB + o]
                          & ((cyc_r[o] + 8'h01 >= cfg.pulse_cycle_count)
                             | (cyc_r[o] == 8'hFF));

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        cyc_r[o] <= '0;
      end else if (!cfg.output_mode_reg[efc_pkg::LATCH_LSB + o]) begin
        cyc_r[o] <= '0;
      end else if (latch_now[o]) begin
        cyc_r[o] <= '0;
      end else if (conv_fall[o]) begin
        cyc_r[o] <= cyc_r[o] + 8'h01;
      end
    end
  end

  assign freq_out_one   = pin_r[0];
  assign freq_out_two   = pin_r[1];
  assign freq_out_three = pin_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Which energy types latch now, and which are held for latching.
  always_comb begin
    latch_type = '0;
    hold_type  = '0;
    for (int t = 0; t < 5; t++) begin
      for (int o = 0; o < 3; o++) begin
        if (cfg.output_mode_reg[efc_pkg::SEL_W*o +: efc_pkg::SEL_W] == 3'(t)) begin
          latch_type[t] = latch_type[t] | latch_now[o];
          hold_type[t]  = hold_type[t] | cfg.output_mode_reg[efc_pkg::LATCH_LSB + o];
        end
      end
    end
  end

  // Internal accumulators and readable copies; every phase latches
  // together, whatever the phase sum selection includes.
  for (genvar t = 0; t < 5; t++) begin : g_type
    for (genvar p = 0; p < 3; p++) begin : g_phase
      efc_pkg::efc_word_t add_c;

      assign add_c = pwr_vld ? 32'(raw_power(3'(t), pwr[p])) : 32'sh0;

      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          eacc_r[t][p] <= '0;
        end else if (latch_type[t]) begin
          eacc_r[t][p] <= add_c;
        end else begin
          eacc_r[t][p] <= eacc_r[t][p] + add_c;
        end
      end

      // Without latching the readable register tracks the accumulator.
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          ereg_r[t][p] <= '0;
        end else if (latch_type[t]) begin
          ereg_r[t][p] <= eacc_r[t][p];
        end else if (!hold_type[t]) begin
          ereg_r[t][p] <= eacc_r[t][p];
        end
      end
    end
  end

  assign energy_regs = ereg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Flags, sign bits and the interrupt line.
  always_comb begin
    flag_set = '0;
    sign_nxt = sign_r;
    for (int o = 0; o < 3; o++) begin
      if (conv_fall[o]) begin
        flag_set[efc_pkg::FALL_FLAG[o]] = 1'b1;
      end
      if (conv_fall[o] && rev_pend_r[o]) begin
        flag_set[efc_pkg::REV_FLAG[o]] = 1'b1;
        sign_nxt[efc_pkg::SIGN_BIT[o]] = last_neg_r[o];
      end
    end
    // A set in the same cycle as its clear wins.
    flag_nxt = (flag_r & ~(flag_wr ? flag_wr_data : 32'h0000_0000)) | flag_set;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r  <= efc_pkg::FLAG_RST;
      sign_r  <= efc_pkg::SIGN_RST;
      irq_b_r <= 1'b1;
    end else begin
      flag_r  <= flag_nxt;
      sign_r  <= sign_nxt;
      irq_b_r <= ~|(flag_nxt & cfg.interrupt_enable_reg0);
    end
  end

  assign event_flag_reg0     = flag_r;
  assign power_sign_reg      = sign_r;
  assign interrupt_line_zero = irq_b_r;

endmodule

// *** common/efc_pkg.sv ***
/*
  Shared constants and carrier types for the energy pulse output stage:
  register field positions, reset values, tick and pulse timing, power
  sample and configuration bundles.
  Assumes a single 125 MHz core clock; configuration words are driven by
  the host register block of the metering device as plain levels.

  //How it works
  //- Pulse drives pin low, idle high.
  //- Pin-disable bits 11:9 default one, hold high.
  //- Enabled falling edges set flag, pull interrupt low.
  //- Edge flags work while pin disabled.
  //- Latch copies selected accumulators, then clears them.
  //- All three phases always latched.
  //- Eight-bit count of edges between latches.
  //- Latch enables bits 14:12, default off.
  //- Active mode bits 1:0, default signed.
  //- Active mode 11 feeds absolute power.
  //- Active modes 01, 10 act signed.
  //- Reactive mode bits 3:2, default signed.
  //- Reactive mode 10 follows active sign.
  //- Reactive mode 11 feeds absolute power.
  //- Reactive mode 01 acts signed.
  //- Sign change flag set at next fall.
  //- Sum sign bits update with reversal flags.
  //- Enabled sign change pulls interrupt low.
  //- Writing one clears flag, releases interrupt.
  //- Low 80 ms on long periods, else half.
  //- Shift seven, accumulate at 1 MHz, divide.
  //- Three-bit power type select per output.
*/
package efc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_HZ       = 125_000_000;
  localparam int TICK_HZ      = 1_000_000;
  localparam int TICK_DIV     = CLK_HZ / TICK_HZ;
  localparam int LOW_TIME_MS  = 80;
  localparam int LOW_TICKS    = LOW_TIME_MS * (TICK_HZ / 1000);
  localparam int SHIFT_BITS   = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int SEL_W        = 3;
  localparam int DIS_LSB      = 9;
  localparam int LATCH_LSB    = 12;
  localparam int WMODE_LSB    = 0;
  localparam int VMODE_LSB    = 2;
  localparam int FALL_FLAG[3] = '{14, 15, 16};
  localparam int REV_FLAG[3]  = '{9, 13, 18};
  localparam int SIGN_BIT[3]  = '{3, 7, 8};

  // Power type codes and accumulation modes.
  localparam logic [2:0] PT_WATT  = 3'h0;
  localparam logic [2:0] PT_VAR   = 3'h1;
  localparam logic [2:0] PT_VA    = 3'h2;
  localparam logic [2:0] PT_FWATT = 3'h3;
  localparam logic [2:0] PT_FVAR  = 3'h4;
  localparam logic [1:0] ACC_ABS  = 2'h3;
  localparam logic [1:0] ACC_SADJ = 2'h2;

  // Values after reset.
  localparam logic [31:0] FLAG_RST = 32'h0000_0000;
  localparam logic [15:0] SIGN_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  typedef logic signed [31:0] efc_word_t;
  typedef efc_word_t [4:0][2:0] efc_energy_t;

  typedef struct packed {
    logic signed [23:0] watt;
    logic signed [23:0] var_p;
    logic signed [23:0] va;
    logic signed [23:0] fwatt;
    logic signed [23:0] fvar;
  } efc_phase_pwr_t;

  typedef efc_phase_pwr_t [2:0] efc_powers_t;

  typedef struct packed {
    logic [14:0]      output_mode_reg;
    logic [8:0]       computation_mode_reg;
    logic [3:0]       accumulation_mode_reg;
    logic [31:0]      interrupt_enable_reg0;
    logic [7:0]       pulse_cycle_count;
    logic [2:0][15:0] pulse_divider;
    logic [23:0]      active_energy_threshold;
    logic [23:0]      reactive_energy_threshold;
    logic [23:0]      apparent_energy_threshold;
  } efc_cfg_t;

endpackage

// *** hw/efc_first_stage.sv ***
/*
  First converter stage: accumulates the shifted phase power sum at the
  1 MHz tick and emits a one-cycle pulse with the sign of the energy
  each time the threshold is crossed.
  Assumes term and threshold are already shifted and held steady.
*/
`timescale 1ns/1ns
module efc_first_stage (
  input  wire logic               core_clk, // Core clock.
  input  wire logic               rst_b,    // Asynchronous reset, low.
  input  wire logic               tick,     // 1 MHz accumulate strobe.
  input  wire logic signed [39:0] term,     // Shifted power sum.
  input  wire logic signed [39:0] thr,      // Shifted threshold.
  output logic                    pulse_r,  // Threshold crossed.
  output logic                    neg_r     // Sign at last crossing.
);

  logic signed [39:0] acc_r;
  logic signed [39:0] sum;

  assign sum = acc_r + term;

  // Subtract the threshold on a positive crossing, add it on a negative one; a zero threshold never fires.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r   <= '0;
      pulse_r <= 1'b0;
      neg_r   <= 1'b0;
    end else begin
      pulse_r <= 1'b0;
      if (tick) begin
        if (thr != 40'sh0 && sum >= thr) begin
          acc_r   <= sum - thr;
          pulse_r <= 1'b1;
          neg_r   <= 1'b0;
        end else if (thr != 40'sh0 && -sum >= thr) begin
          acc_r   <= sum + thr;
          pulse_r <= 1'b1;
          neg_r   <= 1'b1;
        end else begin
          acc_r <= sum;
        end
      end
    end
  end

endmodule

// *** hw/efc_freq_div.sv ***
/*
  Second converter stage: divides first-stage pulses by the divider and
  shapes the active-low output with its low time.
  Assumes one-cycle stage pulses and a 1 MHz tick on the same clock.
*/
`timescale 1ns/1ns
module efc_freq_div #(
  parameter int LOW_TICKS = efc_pkg::LOW_TICKS
) (
  input  wire logic        core_clk, // Core clock.
  input  wire logic        rst_b,    // Asynchronous reset, low.
  input  wire logic        tick,     // 1 MHz strobe.
  input  wire logic        stage,    // First-stage pulse.
  input  wire logic [15:0] den,      // Divider, zero acts as one.
  output logic             out_r,    // Converter output, low active.
  output logic             fall_r    // One cycle on each fall.
);

  logic [15:0] pcnt_r;
  logic [16:0] lowcnt_r;
  logic [16:0] den_eff;
  logic [16:0] half;

  assign den_eff = (den == 16'h0000) ? 17'h00001 : {1'b0, den};
  assign half    = (den_eff + 17'h00001) >> 1;

  // Low for ceil(den/2) stage pulses, capped at the long-period low time.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcnt_r   <= '0;
      lowcnt_r <= '0;
      out_r    <= 1'b1;
      fall_r   <= 1'b0;
    end else begin
      fall_r <= 1'b0;
      if (stage && {1'b0, pcnt_r} + 17'h00001 >= den_eff) begin
        pcnt_r   <= '0;
        out_r    <= 1'b0;
        fall_r   <= 1'b1;
        lowcnt_r <= '0;
      end else begin
        if (stage) begin
          pcnt_r <= pcnt_r + 16'h0001;
        end
        if (!out_r) begin
          if (tick) begin
            lowcnt_r <= lowcnt_r + 17'h00001;
          end
          if ((stage && {1'b0, pcnt_r} + 17'h00001 >= half)
              || (den_eff == 17'h00001 && tick)
              || lowcnt_r >= 17'(LOW_TICKS)) begin
            out_r <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// *** sim/efc_output_stage_properties.sv ***
/*
  Port checker for the energy pulse output stage.
  Assumes one core clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ns
module efc_chk #(
  parameter int LOW_TICKS = efc_pkg::LOW_TICKS
) (
  input wire logic              core_clk,            // Clock.
  input wire logic              rst_b,               // Reset, low.
  input wire efc_pkg::efc_cfg_t cfg,                 // Config.
  input wire logic              flag_wr,             // Clear strobe.
  input wire logic [31:0]       flag_wr_data,        // Clear mask.
  input wire logic              freq_out_one,        // Pin one.
  input wire logic              freq_out_two,        // Pin two.
  input wire logic              freq_out_three,      // Pin three.
  input wire logic              interrupt_line_zero, // Interrupt.
  input wire logic [31:0]       event_flag_reg0,     // Flags.
  input wire logic [15:0]       power_sign_reg       // Signs.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Gate bits and the enabled-flag condition behind the interrupt.
  logic [2:0] dis;
  logic       any_irq;
  assign dis = cfg.output_mode_reg[11:9];
  assign any_irq = |(event_flag_reg0 & cfg.interrupt_enable_reg0);

  ////////////////////////////////////////////////////////////
  // The cycle after a gate change is skipped, as the pins are registered.
  a_pins_gated_high: assert property (
    (dis & $past(dis) & ~{freq_out_three, freq_out_two, freq_out_one}) == 3'h0)
    else $error("gated pin driven low");
  a_fall_flagged: assert property (!dis[0] && !$past(dis[0]) && $fell(freq_out_one)
    |-> event_flag_reg0[14]) else $error("fall of pin one not flagged");
  a_low_min: assert property ($fell(freq_out_one) |-> !freq_out_one [*8])
    else $error("pin one pulse too short");
  a_irq_asserts: assert property (any_irq ##1 ($stable(event_flag_reg0) &&
    $stable(cfg.interrupt_enable_reg0)) |-> !interrupt_line_zero) else $error("irq not low");
  a_irq_releases: assert property (!any_irq ##1 ($stable(event_flag_reg0) &&
    $stable(cfg.interrupt_enable_reg0)) |-> interrupt_line_zero) else $error("irq stuck low");
  a_flags_sticky: assert property (1'b1 |=> ($past(event_flag_reg0) & ~event_flag_reg0 &
    ~({32{$past(flag_wr)}} & $past(flag_wr_data))) == 32'h0) else $error("flag lost");
  a_sign_with_flag: assert property ($past(rst_b) && $changed(power_sign_reg[3])
    |-> event_flag_reg0[9] && event_flag_reg0[14]) else $error("sign moved alone");
  a_rev_with_fall: assert property ($rose(event_flag_reg0[9]) |-> event_flag_reg0[14])
    else $error("reversal flag without fall");
  a_reset_idle: assert property ($rose(rst_b) |-> interrupt_line_zero &&
    {freq_out_one, freq_out_two, freq_out_three} == 3'h7 && event_flag_reg0 == 32'h0 &&
    power_sign_reg == 16'h0) else $error("outputs not idle after reset");

  // Main scenarios reached.
  c_fall: cover property ($fell(freq_out_one));
  c_rev: cover property ($rose(event_flag_reg0[9]));
  c_irq: cover property ($fell(interrupt_line_zero));
endmodule

bind efc_output_stage efc_chk #(.LOW_TICKS(LOW_TICKS)) i_efc_chk (
  .core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .flag_wr(flag_wr),
  .flag_wr_data(flag_wr_data), .freq_out_one(freq_out_one), .freq_out_two(freq_out_two),
  .freq_out_three(freq_out_three), .interrupt_line_zero(interrupt_line_zero),
  .event_flag_reg0(event_flag_reg0), .power_sign_reg(power_sign_reg));

// *** sim/efc_led_model.sv ***
/*
  LED or opto-isolator on one pulse pin: counts flashes.
  Assumes the pin is sampled on the rising core clock edge.
*/
`timescale 1ns/1ns
module efc_led_model (
  input  wire logic        core_clk, // Core clock.
  input  wire logic        pin,      // Pulse pin, low lights.
  output logic      [15:0] flashes   // Flashes seen so far.
);
  logic prev_r;

  // A flash starts when the pin sinks current after idling high.
  initial begin
    prev_r = 1'b1;
    flashes = 16'h0000;
  end
  always @(posedge core_clk) begin
    if (prev_r && !pin) begin
      flashes <= flashes + 16'h0001;
    end
    prev_r <= pin;
  end
endmodule

// *** sim/tb.sv ***
/*
  Self-checking bench for the energy pulse output stage.
  Assumes the bound port checker and an LED model on pin one.
*/
`timescale 1ns/1ns
module tb;
  localparam int LT = 20;

  logic                 core_clk;
  logic                 rst_b;
  logic                 pwr_vld;
  logic                 flag_wr;
  logic                 p1, p2, p3, irq;
  logic [31:0]          flag_wr_data;
  logic [31:0]          event_flag_reg0;
  logic [15:0]          power_sign_reg;
  logic [15:0]          fl1;
  efc_pkg::efc_cfg_t    cfg;
  efc_pkg::efc_powers_t pwr;
  efc_pkg::efc_energy_t energy_regs;
  int                   mismatches;
  int                   checks_done;

  efc_output_stage #(.LOW_TICKS(LT)) i_efc_output_stage (
    .core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .pwr_vld(pwr_vld), .pwr(pwr),
    .flag_wr(flag_wr), .flag_wr_data(flag_wr_data), .freq_out_one(p1),
    .freq_out_two(p2), .freq_out_three(p3), .interrupt_line_zero(irq),
    .event_flag_reg0(event_flag_reg0), .power_sign_reg(power_sign_reg),
    .energy_regs(energy_regs));
  efc_led_model i_efc_led_model (.core_clk(core_clk), .pin(p1), .flashes(fl1));

  // Core clock, 8 ns period.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (exp !== got) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Inputs always move at the falling edge.
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    cyc(10);
    rst_b = 1'b1;
  endtask

  task automatic clear(logic [31:0] m);
    flag_wr = 1'b1;
    flag_wr_data = m;
    cyc(1);
    flag_wr = 1'b0;
    cyc(2);
  endtask

  // Phase p carries (p + 1) times the powers, so a phase mix-up shows.
  task automatic set_pwr(logic signed [23:0] w, logic signed [23:0] v, int n);
    logic signed [23:0] k;
    for (int p = 0; p < 3; p++) begin
      k = 24'(p + 1);
      pwr[p] = '{w * k, v * k, 24'sh000100 * k, w * k, v * k};
    end
    pwr_vld = 1'b1;
    cyc(n);
    pwr_vld = 1'b0;
  endtask

  // Bounded wait for a flash count, then a settle margin for the latch.
  task automatic wait_fl(logic [15:0] n);
    for (int k = 0; k < 3000 && fl1 !== n; k++) begin
      cyc(1);
    end
    cyc(4);
    chk("flashes", n, fl1);
  endtask

  // Returns {fall expected, negative sum expected} for output one.
  function automatic logic [1:0] expect_fl(logic [2:0] sel, logic [1:0] md, logic wn, logic vn);
    logic neg;
    case (sel)
      3'h0, 3'h3: neg = wn && md != 2'h3;
      3'h1, 3'h4: neg = (md == 2'h3) ? 1'b0 : (md == 2'h2) ? (vn ^ wn) : vn;
      default: neg = 1'b0;
    endcase
    return {sel < 3'h5, neg};
  endfunction

  // Pin one gated off throughout; flags, sign and energy still move.
  task automatic run_case(logic [2:0] sel, logic [1:0] md, logic wn, logic vn);
    logic [1:0]         e;
    logic [15:0]        f;
    logic signed [23:0] w, v;
    e = expect_fl(sel, md, wn, vn);
    w = wn ? -24'sh0001F4 : 24'sh0001F4;
    v = vn ? -24'sh0001F4 : 24'sh0001F4;
    cfg.output_mode_reg = {3'h0, 3'h7, 3'h2, 3'h1, sel};
    cfg.accumulation_mode_reg = {md, md};
    cfg.interrupt_enable_reg0 = 32'h0000_4200;
    do_reset();
    f = fl1;
    set_pwr(w, v, 1);
    cyc(2000);
    chk("fall flag", e[1], event_flag_reg0[14]);
    chk("reversal", e[0], event_flag_reg0[9]);
    chk("sum sign", e[0], power_sign_reg[3]);
    chk("irq", !e[1], irq);
    chk("gated pin", f, fl1);
    chk("active energy", w, energy_regs[0][0]);
    chk("reactive energy", v, energy_regs[1][0]);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [15:0] f;
    rst_b = 1'b0;
    pwr_vld = 1'b0;
    flag_wr = 1'b0;
    flag_wr_data = 32'h0;
    pwr = '0;
    mismatches = 0;
    checks_done = 0;
    cfg = '0;
    cfg.output_mode_reg = 15'h0E88;
    cfg.computation_mode_reg = 9'h1FF;
    cfg.pulse_cycle_count = 8'h01;
    cfg.pulse_divider = {3{16'h0002}};
    cfg.active_energy_threshold = 24'h000BB8;
    cfg.reactive_energy_threshold = 24'h000BB8;
    cfg.apparent_energy_threshold = 24'h000600;
    void'($urandom(32'hAE3C036F));
    do_reset();
    chk("idle pins", 3'h7, {p1, p2, p3});
    chk("idle irq", 1'b1, irq);
    chk("idle flags", 32'h0, event_flag_reg0);
    chk("idle energy", 32'h0, energy_regs[0][0]);
    // Every power type under every mode, with random signs.
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      run_case(3'(i % 6), 2'(i / 6), r[0], r[1]);
    end
    // Negative sum, then clear the two flags one at a time.
    run_case(3'h0, 2'h0, 1'b1, 1'b0);
    set_pwr(24'sh000000, 24'sh000000, 1);
    cyc(300);
    chk("sign read", 1'b1, power_sign_reg[3]);
    clear(32'h0000_4000);
    chk("unwritten kept", 1'b1, event_flag_reg0[9]);
    chk("irq held", 1'b0, irq);
    clear(32'h0000_0200);
    chk("cleared", 32'h0, event_flag_reg0 & 32'h0000_4200);
    chk("irq released", 1'b1, irq);
    // Latch on every second fall of output one, phase A alone in its sum.
    cfg.output_mode_reg = 15'h1088;
    cfg.computation_mode_reg = 9'h1F9;
    cfg.pulse_cycle_count = 8'h02;
    cfg.active_energy_threshold = 24'h0001F4;
    do_reset();
    f = fl1;
    set_pwr(24'sh0001F4, 24'sh00012C, 5);
    wait_fl(f + 16'h0001);
    chk("before latch", 32'h0, energy_regs[0][1]);
    chk("unlatched type", 32'h0000_0BB8, energy_regs[1][1]);
    wait_fl(f + 16'h0002);
    for (int p = 0; p < 3; p++) begin
      chk("latched", 32'(2500 * (p + 1)), energy_regs[0][p]);
    end
    wait_fl(f + 16'h0004);
    chk("restarted", 32'h0, energy_regs[0][2]);
    wrap_up();
  end

  // About 52k cycles are expected; the limit stays under 100k cycles.
  initial begin
    #700_000;
    mismatches++;
    wrap_up();
  end
endmodule
